// [debug_comparator_consts.vh]
// constants for the debug comparator match registers
`ifndef DEBUG_COMPARATOR_CONSTS_VH
`define DEBUG_COMPARATOR_CONSTS_VH

// register indices; byte address is four times the index
`define DCM_IDX_CTRL 8'h20
`define DCM_IDX_ADDR_HIGH 8'h29
`define DCM_IDX_ADDR_MID 8'h2a
`define DCM_IDX_ADDR_LOW 8'h2b
`define DCM_IDX_DATA_HIGH 8'h2c

// word index taken from haddr
`define DCM_HADDR_IDX_HI 9
`define DCM_HADDR_IDX_LO 2

// control register fields
`define DCM_CTRL_ARM_BIT 7
`define DCM_CTRL_WSEL_HI 1
`define DCM_CTRL_WSEL_LO 0

// window-select codes
`define DCM_WSEL_A 2'h0
`define DCM_WSEL_B 2'h1
`define DCM_WSEL_C 2'h2
`define DCM_WSEL_NONE 2'h3

// monitored address and data slices
`define DCM_ADDR_HIGH_HI 17
`define DCM_ADDR_HIGH_LO 16
`define DCM_ADDR_MID_HI 15
`define DCM_ADDR_MID_LO 8
`define DCM_ADDR_LOW_HI 7
`define DCM_ADDR_LOW_LO 0
`define DCM_DATA_HIGH_HI 15
`define DCM_DATA_HIGH_LO 8

// write data slices
`define DCM_WDATA_BYTE_HI 7
`define DCM_WDATA_BYTE_LO 0
`define DCM_WDATA_HIGH_HI 1
`define DCM_WDATA_HIGH_LO 0

// bus qualifier bit and the comparator that owns the data byte
`define DCM_HTRANS_ACTIVE_BIT 1
`define DCM_DATA_CMP 0
`define DCM_ZERO_SEL_PAD 30'h00000000

// reset and fill values
`define DCM_RST_BYTE 8'h00
`define DCM_RST_ADDR 18'h00000
`define DCM_RST_WSEL 2'h0
`define DCM_ZERO_HIGH6 6'h00
`define DCM_ZERO_CTRL5 5'h00
`define DCM_ZERO_WORD_PAD 24'h000000
`define DCM_RST_WORD 32'h00000000
`define DCM_HRESP_OKAY 1'b0

`endif

// [debug_comparator_match_regs.v]
// comparator address/data match registers behind an AHB-Lite slave
`default_nettype none
`include "debug_comparator_consts.vh"

module debug_comparator_match_regs #(
  parameter NUM_CMP = 3
)(
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [17:0] monAddr,
  input wire [15:0] monData,
  input wire [7:0] dataHighMask,
  input wire tagSelectA,
  output reg armed,
  output reg [1:0] windowSelect,
  output reg [NUM_CMP-1:0] compareMatch
);

  localparam ADDR_BITS = `DCM_ADDR_HIGH_HI + 1;
  localparam DATA_BITS = `DCM_DATA_HIGH_HI - `DCM_DATA_HIGH_LO + 1;

  reg dpWrite;
  reg [7:0] dpIdx;
  reg [7:0] dataHigh;
  wire takeReq;
  wire wrCtrl;
  wire wrAllowed;
  reg next_armed;
  reg [1:0] next_windowSelect;
  reg [7:0] next_dataHigh;
  wire [7:0] aIdx;
  wire dataOk;
  wire [NUM_CMP-1:0] next_match;
  reg [7:0] rdByte;

  // decoded requests, per-bit compares and the shared window view
  wire takeRead;
  wire takeWrite;
  wire wrHigh;
  wire wrMid;
  wire wrLow;
  wire wrData;
  wire [DATA_BITS-1:0] dataBitOk;
  reg [7:0] winHigh;
  reg [7:0] winMid;
  reg [7:0] winLow;
  genvar b;

  // only single word transfers are issued, so hsize needs no decode
  assign takeReq = hsel & htrans[`DCM_HTRANS_ACTIVE_BIT] & hready;
  assign takeRead = takeReq & ~hwrite;
  assign takeWrite = takeReq & hwrite;
  // haddr bits outside the index are ignored, so the map aliases
  assign aIdx = haddr[`DCM_HADDR_IDX_HI:`DCM_HADDR_IDX_LO];
  assign wrCtrl = dpWrite & (dpIdx == `DCM_IDX_CTRL);
  assign wrAllowed = dpWrite & ~armed;
  // write decode runs on the held data-phase index
  assign wrHigh = wrAllowed & (dpIdx == `DCM_IDX_ADDR_HIGH);
  assign wrMid = wrAllowed & (dpIdx == `DCM_IDX_ADDR_MID);
  assign wrLow = wrAllowed & (dpIdx == `DCM_IDX_ADDR_LOW);
  assign wrData = wrAllowed & (dpIdx == `DCM_IDX_DATA_HIGH);

  // control write is never gated by arming
  always @*
  begin
    next_armed = armed;
    next_windowSelect = windowSelect;
    if (wrCtrl)
    begin
      next_armed = hwdata[`DCM_CTRL_ARM_BIT];
      next_windowSelect = hwdata[`DCM_CTRL_WSEL_HI:`DCM_CTRL_WSEL_LO];
    end
  end

  // gating uses the select and arm state from before this write
  always @*
  begin
    next_dataHigh = dataHigh;
    if (wrData & (windowSelect == `DCM_WSEL_A))
      next_dataHigh = hwdata[`DCM_WDATA_BYTE_HI:`DCM_WDATA_BYTE_LO];
  end

  // masked compare of the upper data byte, comparator A only
  generate
    for (b = 0; b < DATA_BITS; b = b + 1)
    begin : dataCmp
      // a clear mask bit lets any level through
      assign dataBitOk[b] = ~dataHighMask[b] |
        (monData[`DCM_DATA_HIGH_LO + b] == dataHigh[b]);
    end
  endgenerate

  // tag-select defers to the opcode tag, so the data byte is moot
  assign dataOk = tagSelectA | (&dataBitOk);

  genvar i;
  generate
    for (i = 0; i < NUM_CMP; i = i + 1)
    begin : cmp
      reg [17:0] addrCmp;
      wire hit;
      wire [17:0] next_addr;
      wire [ADDR_BITS-1:0] addrBitOk;
      wire [7:0] rdHigh;
      wire [7:0] rdMid;
      wire [7:0] rdLow;
      // the comparator's own code in the window-select field
      localparam integer SEL = i;
      // window 11 matches no index, so writes there vanish
      assign hit = ({`DCM_ZERO_SEL_PAD, windowSelect} == SEL);
      assign next_addr = {
        (hit & wrHigh) ?
          hwdata[`DCM_WDATA_HIGH_HI:`DCM_WDATA_HIGH_LO] :
          addrCmp[`DCM_ADDR_HIGH_HI:`DCM_ADDR_HIGH_LO],
        (hit & wrMid) ?
          hwdata[`DCM_WDATA_BYTE_HI:`DCM_WDATA_BYTE_LO] :
          addrCmp[`DCM_ADDR_MID_HI:`DCM_ADDR_MID_LO],
        (hit & wrLow) ?
          hwdata[`DCM_WDATA_BYTE_HI:`DCM_WDATA_BYTE_LO] :
          addrCmp[`DCM_ADDR_LOW_HI:`DCM_ADDR_LOW_LO]};

      // read view uses next values, so a write is seen at once
      assign rdHigh = {`DCM_ZERO_HIGH6,
        next_addr[`DCM_ADDR_HIGH_HI:`DCM_ADDR_HIGH_LO]};
      assign rdMid = next_addr[`DCM_ADDR_MID_HI:`DCM_ADDR_MID_LO];
      assign rdLow = next_addr[`DCM_ADDR_LOW_HI:`DCM_ADDR_LOW_LO];
      // each stored bit is the level its address bit must show
      for (b = 0; b < ADDR_BITS; b = b + 1)
      begin : bitCmp
        assign addrBitOk[b] = addrCmp[b] ? monAddr[b] : ~monAddr[b];
      end
      // only comparator A carries the data byte
      if (i == `DCM_DATA_CMP)
      begin : withData
        assign next_match[i] = (&addrBitOk) & dataOk;
      end
      else
      begin : addrOnly
        assign next_match[i] = &addrBitOk;
      end
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          addrCmp <= `DCM_RST_ADDR;
        else
          addrCmp <= next_addr;
      end
    end
  endgenerate

  // window view of the comparator chosen by the updated select field;
  // the three-way select assumes NUM_CMP stays at three
  always @*
  begin
    winHigh = `DCM_RST_BYTE;
    winMid = `DCM_RST_BYTE;
    winLow = `DCM_RST_BYTE;
    case (next_windowSelect)
      `DCM_WSEL_A:
      begin
        winHigh = cmp[0].rdHigh;
        winMid = cmp[0].rdMid;
        winLow = cmp[0].rdLow;
      end
      `DCM_WSEL_B:
      begin
        winHigh = cmp[1].rdHigh;
        winMid = cmp[1].rdMid;
        winLow = cmp[1].rdLow;
      end
      `DCM_WSEL_C:
      begin
        winHigh = cmp[2].rdHigh;
        winMid = cmp[2].rdMid;
        winLow = cmp[2].rdLow;
      end
      default:
      begin
        winHigh = `DCM_RST_BYTE;
        winMid = `DCM_RST_BYTE;
        winLow = `DCM_RST_BYTE;
      end
    endcase
  end

  // read from next values so a read right after a write sees it
  always @*
  begin
    rdByte = `DCM_RST_BYTE;
    case (aIdx)
      `DCM_IDX_CTRL:
        rdByte = {next_armed, `DCM_ZERO_CTRL5, next_windowSelect};
      `DCM_IDX_ADDR_HIGH:
        rdByte = winHigh;
      `DCM_IDX_ADDR_MID:
        rdByte = winMid;
      `DCM_IDX_ADDR_LOW:
        rdByte = winLow;
      `DCM_IDX_DATA_HIGH:
      begin
        if (next_windowSelect == `DCM_WSEL_A)
          rdByte = next_dataHigh;
      end
      default:
        rdByte = `DCM_RST_BYTE;
    endcase
  end

  // data-phase pipeline: the write lands one cycle after its address
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dpWrite <= 1'b0;
      dpIdx <= `DCM_RST_BYTE;
    end
    else
    begin
      dpWrite <= takeWrite;
      dpIdx <= aIdx;
    end
  end

  // control stays writable while armed, or the unit could never disarm
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      armed <= 1'b0;
      windowSelect <= `DCM_RST_WSEL;
    end
    else
    begin
      armed <= next_armed;
      windowSelect <= next_windowSelect;
    end
  end

  // data high exists for comparator A only
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      dataHigh <= `DCM_RST_BYTE;
    else
      dataHigh <= next_dataHigh;
  end

  // matches ignore arming; gating them is the sequencer's job
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      compareMatch <= {NUM_CMP{1'b0}};
    else
      compareMatch <= next_match;
  end

  // zero wait states: every transfer completes in its data phase
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= `DCM_HRESP_OKAY;
      hrdata <= `DCM_RST_WORD;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= `DCM_HRESP_OKAY;
      // loaded at the address edge, held through the data phase
      if (takeRead)
        hrdata <= {`DCM_ZERO_WORD_PAD, rdByte};
    end
  end

endmodule
`default_nettype wire

// [debug_comparator_match_regs_chk.sv]
// assertions for the comparator match registers
`default_nettype none
module debug_comparator_match_regs_chk #(parameter NUM_CMP = 3)(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic armed,
  input wire logic [1:0] windowSelect,
  input wire logic [NUM_CMP-1:0] compareMatch
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic go = hsel && htrans[1] && hready;
  wire logic rd = go && !hwrite;
  wire logic ctl = go && hwrite && haddr[9:2] == 8'h20;
  wire logic [7:0] ix = haddr[9:2];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // window state is judged one cycle on, so forwarded writes count
  chk_none_zero: assert property (rd && ix > 8'h28 && ix < 8'h2d |=>
    windowSelect != 2'h3 || hrdata == 32'h0) else $error("window not zero");
  chk_dh_hidden: assert property (rd && ix == 8'h2c |=>
    windowSelect == 2'h0 || hrdata == 32'h0) else $error("data high seen");
  chk_high_pad: assert property (rd && ix == 8'h29 |=>
    hrdata[31:2] == 30'h0) else $error("high pad bits set");
  chk_ctl_load: assert property (ctl ##1 1'h1 |=> armed ==
    $past(hwdata[7]) && windowSelect == $past(hwdata[1:0]))
    else $error("control not loaded");
  chk_ws_cause: assert property ($changed(windowSelect) |->
    $past(ctl, 2)) else $error("window moved alone");
  chk_arm_cause: assert property ($changed(armed) |->
    $past(ctl, 2)) else $error("arm moved alone");
  chk_rd_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  chk_rd_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  cover property (compareMatch[0]);
  cover property (compareMatch[NUM_CMP-1]);
  cover property (rd && armed);
endmodule
bind debug_comparator_match_regs debug_comparator_match_regs_chk
  #(.NUM_CMP(NUM_CMP)) u_chk (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .armed(armed), .windowSelect(windowSelect),
  .compareMatch(compareMatch));
`default_nettype wire

// [debug_cpu_bus_model.sv]
// model of the monitored cpu address and data bus
`default_nettype none
module debug_cpu_bus_model (
  input wire logic clk,
  input wire logic [17:0] wantA,
  input wire logic [15:0] wantD,
  output logic [17:0] monAddr = 18'h0,
  output logic [15:0] monData = 16'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus moves only at edges, as the cpu does
  always @(posedge clk)
  begin
    monAddr <= wantA;
    monData <= wantD;
  end
endmodule
`default_nettype wire

// [tb_debug_comparator_match_regs.sv]
// testbench for the comparator match registers
`default_nettype none
module tb_debug_comparator_match_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, tag = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] mask = 8'h0;
  logic [17:0] wantA = 18'h0;
  logic [15:0] wantD = 16'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, armed;
  wire logic [1:0] ws;
  wire logic [2:0] cm;
  wire logic [17:0] monAddr;
  wire logic [15:0] monData;
  int n_mismatch = 0, num_checks = 0;
  always #50 clk = ~clk;
  debug_cpu_bus_model u_bus (.clk(clk), .wantA(wantA), .wantD(wantD),
    .monAddr(monAddr), .monData(monData));
  debug_comparator_match_regs u_dut (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .monAddr(monAddr), .monData(monData),
    .dataHighMask(mask), .tagSelectA(tag), .armed(armed),
    .windowSelect(ws), .compareMatch(cm));
  task results;
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task xf(input logic w, input logic [7:0] ix, d, e);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= {22'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'h1);
    if (!w) check(hrdata, {24'h0, e});
  endtask
  // bus model adds a cycle before the match register sees it
  task mon(input logic [17:0] a, input logic [15:0] d,
    input logic [7:0] m, input logic t, input logic [2:0] e);
    @(posedge clk);
    wantA <= a;
    wantD <= d;
    mask <= m;
    tag <= t;
    repeat (3) @(posedge clk);
    #1 check({29'h0, cm}, {29'h0, e});
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    results;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    xf(0, 8'h2c, 8'h0, 8'h0);
    xf(1, 8'h29, 8'hff, 8'h0);
    xf(0, 8'h29, 8'h0, 8'h03);
    xf(1, 8'h2a, 8'h5a, 8'h0);
    xf(1, 8'h2b, 8'hc3, 8'h0);
    xf(1, 8'h2c, 8'ha5, 8'h0);
    xf(0, 8'h2c, 8'h0, 8'ha5);
    xf(1, 8'h20, 8'h01, 8'h0);
    xf(1, 8'h29, 8'h02, 8'h0);
    xf(1, 8'h2a, 8'h12, 8'h0);
    xf(1, 8'h2b, 8'h34, 8'h0);
    xf(1, 8'h2c, 8'h11, 8'h0);
    xf(0, 8'h2c, 8'h0, 8'h0);
    xf(0, 8'h2a, 8'h0, 8'h12);
    xf(1, 8'h20, 8'h02, 8'h0);
    xf(1, 8'h29, 8'h01, 8'h0);
    xf(1, 8'h2b, 8'hff, 8'h0);
    xf(1, 8'h20, 8'h03, 8'h0);
    #1 check({29'h0, armed, ws}, 32'h3);
    xf(1, 8'h2b, 8'h77, 8'h0);
    xf(0, 8'h2b, 8'h0, 8'h0);
    xf(0, 8'h30, 8'h0, 8'h0);
    xf(1, 8'h20, 8'h80, 8'h0);
    #1 check({29'h0, armed, ws}, 32'h4);
    xf(1, 8'h2a, 8'h00, 8'h0);
    xf(1, 8'h2c, 8'h00, 8'h0);
    xf(0, 8'h2a, 8'h0, 8'h5a);
    xf(0, 8'h2c, 8'h0, 8'ha5);
    xf(0, 8'h20, 8'h0, 8'h80);
    xf(1, 8'h20, 8'h02, 8'h0);
    xf(0, 8'h2b, 8'h0, 8'hff);
    mon(18'h35ac3, 16'ha500, 8'hff, 1'h0, 3'h1);
    mon(18'h35ac3, 16'ha400, 8'hff, 1'h0, 3'h0);
    mon(18'h35ac3, 16'h5a00, 8'h00, 1'h0, 3'h1);
    mon(18'h35ac3, 16'h5a00, 8'h01, 1'h0, 3'h0);
    mon(18'h35ac3, 16'h5aff, 8'hff, 1'h1, 3'h1);
    mon(18'h35ac2, 16'ha500, 8'hff, 1'h0, 3'h0);
    mon(18'h25ac3, 16'ha500, 8'hff, 1'h0, 3'h0);
    mon(18'h34ac3, 16'ha500, 8'hff, 1'h0, 3'h0);
    mon(18'h21234, 16'hffff, 8'hff, 1'h0, 3'h2);
    mon(18'h100ff, 16'h0000, 8'hff, 1'h0, 3'h4);
    results;
  end
endmodule
`default_nettype wire
